// file: pkg/scs_consts.svh
// Constants of the smart card supervisor: opcodes, fields, reset values, timing.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
// Clock rate and derived cycle counts
`define SCS_CLK_KHZ   10000
`define SCS_GAP_NS    500
`define SCS_GAP_CYC   ((`SCS_GAP_NS * `SCS_CLK_KHZ + 999999) / 1000000)
`define SCS_FILT_US   50
`define SCS_FILT_CYC  ((`SCS_FILT_US * `SCS_CLK_KHZ) / 1000)
// Command prefixes in bits 7:5
`define SCS_PFX_PROG  3'h4
`define SCS_PFX_CFG   3'h5
`define SCS_PFX_SYNC  3'h6
// Command field positions
`define SCS_B_RST     4
`define SCS_B_IO      2
// Configuration codes in bits 4:0 of a configuration byte
`define SCS_CFG_NO    5'h00
`define SCS_CFG_NC    5'h01
`define SCS_CFG_SPEC  5'h02
`define SCS_CFG_NORM  5'h03
`define SCS_CFG_SLOW  5'h04
`define SCS_CFG_FAST  5'h05
// Reset values
`define SCS_RST_SUPPLY 2'h0
`define SCS_RST_DIV    2'h0
// Readback bit positions
`define SCS_RB_DET    4
`define SCS_RB_IO     3
`define SCS_RB_AUXA   2
`define SCS_RB_AUXB   1
`define SCS_RB_PWR    0
`endif

// file: pkg/scs_pkg.sv
// Types shared by the smart card supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package scs_pkg;
  typedef struct packed {
    logic nc_switch;
    logic special_mode;
    logic fast_slope;
    logic sync_mode;
  } scs_cfg_t;
  typedef struct packed {
    logic       rst;
    logic [1:0] div;
    logic [1:0] supply;
  } scs_card_t;
  typedef enum logic [2:0] {PD_IDLE, PD_RST, PD_CLK, PD_AUX, PD_IO, PD_SUP} scs_pd_t;
endpackage : scs_pkg

// file: rtl/scs_detect_filter.sv
// Digital filter for the card presence pin.
// Assumes the raw pin is already synchronous to the clock.
`timescale 1ns/1ps
module scs_detect_filter #(
  parameter int CYC = 500
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output logic      level_ff,
  output logic      change_ff
);
  logic [$clog2(CYC+1)-1:0] cnt_ff;
  // New level only after it held for the whole interval; one pulse per change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff    <= '0;
      level_ff  <= 1'b0;
      change_ff <= 1'b0;
    end else begin
      change_ff <= 1'b0;
      if (raw == level_ff) begin
        cnt_ff <= '0; // A glitch restarts the wait
      end else if (cnt_ff == ($bits(cnt_ff))'(CYC - 1)) begin
        cnt_ff    <= '0;
        level_ff  <= raw;
        change_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
endmodule : scs_detect_filter

// file: rtl/scs_pdown_seq.sv
// Ordered power-down stepper: reset, clock, aux, io, supply, fixed gap apart.
// Assumes start is a pulse taken only while idle.
`timescale 1ns/1ps
module scs_pdown_seq #(
  parameter int GAP = 5
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      start,
  output scs_pkg::scs_pd_t stage_ff,
  output logic           done_ff
);
  logic [$clog2(GAP+1)-1:0] cnt_ff;
  // Step through the stages, holding each for GAP cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_ff <= scs_pkg::PD_IDLE;
      cnt_ff   <= '0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (stage_ff == scs_pkg::PD_IDLE) begin
        cnt_ff <= '0;
        if (start) begin
          stage_ff <= scs_pkg::PD_RST;
        end
      end else if (cnt_ff != ($bits(cnt_ff))'(GAP - 1)) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else begin
        cnt_ff <= '0;
        case (stage_ff)
          scs_pkg::PD_RST: stage_ff <= scs_pkg::PD_CLK;
          scs_pkg::PD_CLK: stage_ff <= scs_pkg::PD_AUX;
          scs_pkg::PD_AUX: stage_ff <= scs_pkg::PD_IO;
          scs_pkg::PD_IO:  stage_ff <= scs_pkg::PD_SUP;
          scs_pkg::PD_SUP: begin
            stage_ff <= scs_pkg::PD_IDLE;
            done_ff  <= 1'b1;
          end
          default: stage_ff <= scs_pkg::PD_IDLE;
        endcase
      end
    end
  end
endmodule : scs_pdown_seq

// file: rtl/scs_supervisor.sv
// Smart card supervisor top: command decode, detect, power control, interrupt.
// Assumes command bytes arrive already deserialised with a one-cycle valid,
// and every input is synchronous to CLOCK.
`timescale 1ns/1ps
`include "scs_consts.svh"
module scs_supervisor #(
  parameter int FILT_CYC = `SCS_FILT_CYC,
  parameter int GAP_CYC  = `SCS_GAP_CYC
) (
  input  wire logic       CLOCK,
  input  wire logic       RESET_N,
  input  wire logic       CS_N,
  input  wire logic       CMD_VALID,
  input  wire logic [7:0] COMMAND_BYTE,
  input  wire logic       CARD_PRESENCE_IN,
  input  wire logic       SUPPLY_OK,
  input  wire logic       SUPPLY_ABOVE_MIN,
  input  wire logic       HOST_IO_IN,
  input  wire logic       CARD_IO_LINE_IN,
  input  wire logic       CARD_AUX_A_IN,
  input  wire logic       CARD_AUX_B_IN,
  input  wire logic       IO_PULLUP_SELECT,
  output logic [7:0]      READBACK,
  output logic            CARD_RESET_OUT,
  output logic [1:0]      CARD_CLOCK_DIV,
  output logic            CARD_CLOCK_OUT,
  output logic            CLOCK_FAST_SLOPE,
  output logic [1:0]      CARD_SUPPLY,
  output logic            CONVERTER_EN,
  output logic            CARD_IO_LINE_OUT,
  output logic            CARD_IO_LINE_OE,
  output logic            HOST_IO_OUT,
  output logic            HOST_IO_OE,
  output logic            CARD_AUX_A_OUT,
  output logic            CARD_AUX_B_OUT,
  output logic            CARD_AUX_OE,
  output logic            IO_PULLUP_EN,
  output logic            INT_N_OUT,
  output logic            INT_N_OE
);
  scs_pkg::scs_cfg_t  cfg_ff;
  scs_pkg::scs_card_t card_ff;
  scs_pkg::scs_pd_t   pd_stage;
  logic [3:0]         sdat_ff; // clk, io, aux a, aux b for sync cards
  logic               ramped_ff;
  logic               fault_seen_ff;
  logic               int_ins_ff;
  logic               int_ovl_ff;
  logic               filt_lvl;
  logic               filt_chg;
  logic               pd_done;
  logic               take;
  logic [2:0]         pfx;
  logic               addr_hit;
  logic               is_prog;
  logic               is_sync;
  logic               is_cfg;
  logic               sel_clear;
  logic               supply_on;
  logic               present;
  logic               host_off;
  logic               extract;
  logic               fault_det;
  logic               pd_start;
  logic               live;
  logic               io_data;

  // Command decode; only bytes seen while chip select is low count
  assign take     = CMD_VALID && !CS_N;
  assign pfx      = COMMAND_BYTE[7:5];
  assign addr_hit = !pfx[2] && (COMMAND_BYTE[6:5] == {CARD_AUX_A_IN, CARD_AUX_B_IN});
  assign is_prog  = take && (addr_hit || pfx == `SCS_PFX_PROG);
  assign is_sync  = take && (pfx == `SCS_PFX_SYNC);
  assign is_cfg   = take && (pfx == `SCS_PFX_CFG);
  assign sel_clear = take && (addr_hit || pfx == `SCS_PFX_CFG);

  // Detect filter and power-down stepper
  scs_detect_filter #(.CYC(FILT_CYC)) u_filt (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .raw      (CARD_PRESENCE_IN),
    .level_ff (filt_lvl),
    .change_ff(filt_chg)
  );
  scs_pdown_seq #(.GAP(GAP_CYC)) u_pd (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .start   (pd_start),
    .stage_ff(pd_stage),
    .done_ff (pd_done)
  );

  // Pin high means present with a normally open switch
  assign present   = filt_lvl ^ cfg_ff.nc_switch;
  assign supply_on = card_ff.supply != `SCS_RST_SUPPLY;
  assign host_off  = is_prog && (COMMAND_BYTE[1:0] == 2'h0) && supply_on;
  assign extract   = filt_chg && (filt_lvl == cfg_ff.nc_switch) && supply_on;
  // The supply collapse that ends our own power-down is not a fault, so only
  // an idle stepper with no finish pending may see one
  assign fault_det = supply_on && ramped_ff && !SUPPLY_OK && !fault_seen_ff &&
                     pd_stage == scs_pkg::PD_IDLE && !pd_done;
  assign pd_start  = (pd_stage == scs_pkg::PD_IDLE) && (host_off || extract || fault_det);
  assign live      = supply_on && ramped_ff;
  // Our own pull on the host line must not echo back onto the card line
  assign io_data   = cfg_ff.sync_mode ? sdat_ff[2] : (HOST_IO_IN || HOST_IO_OE);

  // Configuration bytes; card reset drops on any of them, whatever their bit 4 holds
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      cfg_ff <= '{nc_switch: 1'b0, special_mode: 1'b1, fast_slope: 1'b0,
                  sync_mode: 1'b0};
    end else begin
      if (is_cfg) begin
        case (COMMAND_BYTE[4:0])
          `SCS_CFG_NO:   cfg_ff.nc_switch    <= 1'b0;
          `SCS_CFG_NC:   cfg_ff.nc_switch    <= 1'b1;
          `SCS_CFG_SPEC: cfg_ff.special_mode <= 1'b1;
          `SCS_CFG_NORM: cfg_ff.special_mode <= 1'b0;
          `SCS_CFG_SLOW: cfg_ff.fast_slope   <= 1'b0;
          `SCS_CFG_FAST: cfg_ff.fast_slope   <= 1'b1;
          default:       cfg_ff.nc_switch    <= cfg_ff.nc_switch; // Reserved codes
        endcase
      end
      // Mode switches itself: a sync byte enters sync, an addressed byte leaves
      if (is_sync) begin
        cfg_ff.sync_mode <= 1'b1;
      end else if (take && addr_hit) begin
        cfg_ff.sync_mode <= 1'b0;
      end
    end
  end

  // Card programming; a zero supply request waits for the stepper to finish
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      card_ff <= '{rst: 1'b0, div: `SCS_RST_DIV, supply: `SCS_RST_SUPPLY};
      sdat_ff <= 4'h0;
    end else begin
      if (is_prog) begin
        card_ff.rst <= COMMAND_BYTE[`SCS_B_RST];
        card_ff.div <= COMMAND_BYTE[3:2];
        // Supply changes are locked out while a power-down is running
        if (COMMAND_BYTE[1:0] != 2'h0 && pd_stage == scs_pkg::PD_IDLE && !pd_start) begin
          card_ff.supply <= COMMAND_BYTE[1:0];
        end
      end else if (is_sync) begin
        card_ff.rst <= COMMAND_BYTE[`SCS_B_RST];
        sdat_ff     <= COMMAND_BYTE[3:0];
      end else if (is_cfg) begin
        card_ff.rst <= 1'b0;
      end
      if (pd_done) begin
        card_ff.supply <= `SCS_RST_SUPPLY;
        card_ff.rst    <= 1'b0;
        sdat_ff        <= 4'h0;
      end
    end
  end

  // Ramp and fault tracking for the supply monitor
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ramped_ff     <= 1'b0;
      fault_seen_ff <= 1'b0;
    end else begin
      if (!supply_on || pd_done) begin
        ramped_ff <= 1'b0;
      end else if (SUPPLY_ABOVE_MIN) begin
        ramped_ff <= 1'b1;
      end
      if (pd_done) begin
        fault_seen_ff <= 1'b0;
      end else if (fault_det) begin
        fault_seen_ff <= 1'b1;
      end
    end
  end

  // Interrupt sources; a new event wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      int_ins_ff <= 1'b0;
      int_ovl_ff <= 1'b0;
    end else begin
      if (filt_chg) begin
        int_ins_ff <= 1'b1;
      end else if (sel_clear) begin
        int_ins_ff <= 1'b0;
      end
      if (fault_det) begin
        int_ovl_ff <= 1'b1;
      end else if (sel_clear && (pfx == `SCS_PFX_CFG || COMMAND_BYTE[1:0] == 2'h0)) begin
        int_ovl_ff <= 1'b0;
      end
    end
  end

  // Pin drivers; forcing by stage keeps the power-down order at the pins
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CARD_RESET_OUT   <= 1'b0;
      CARD_CLOCK_DIV   <= `SCS_RST_DIV;
      CARD_CLOCK_OUT   <= 1'b0;
      CLOCK_FAST_SLOPE <= 1'b0;
      CARD_SUPPLY      <= `SCS_RST_SUPPLY;
      CONVERTER_EN     <= 1'b0;
      CARD_AUX_A_OUT   <= 1'b0;
      CARD_AUX_B_OUT   <= 1'b0;
      CARD_AUX_OE      <= 1'b0;
    end else begin
      CARD_RESET_OUT   <= live && pd_stage < scs_pkg::PD_RST && card_ff.rst;
      CARD_CLOCK_DIV   <= (live && pd_stage < scs_pkg::PD_CLK && !cfg_ff.sync_mode) ?
                          card_ff.div : 2'h0;
      CARD_CLOCK_OUT   <= live && pd_stage < scs_pkg::PD_CLK && cfg_ff.sync_mode && sdat_ff[3];
      CLOCK_FAST_SLOPE <= cfg_ff.fast_slope;
      CARD_SUPPLY      <= (pd_stage == scs_pkg::PD_SUP) ? 2'h0 : card_ff.supply;
      CONVERTER_EN     <= supply_on && !fault_seen_ff && !fault_det &&
                          pd_stage != scs_pkg::PD_SUP;
      // Aux drive only host data; card data on them returns through readback bits 2 and 1
      CARD_AUX_A_OUT   <= live && pd_stage < scs_pkg::PD_AUX && sdat_ff[1];
      CARD_AUX_B_OUT   <= live && pd_stage < scs_pkg::PD_AUX && sdat_ff[0];
      CARD_AUX_OE      <= cfg_ff.sync_mode;
    end
  end

  // Open-drain card io and host io; the host side is not driven while we
  // pull the card low, which would otherwise latch both lines low
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CARD_IO_LINE_OUT <= 1'b0;
      CARD_IO_LINE_OE  <= 1'b0;
      HOST_IO_OUT      <= 1'b0;
      HOST_IO_OE       <= 1'b0;
      IO_PULLUP_EN     <= 1'b0;
    end else begin
      CARD_IO_LINE_OUT <= 1'b0;
      CARD_IO_LINE_OE  <= supply_on && (!live || pd_stage >= scs_pkg::PD_IO ||
                          (!CS_N && !io_data));
      HOST_IO_OUT      <= 1'b0;
      HOST_IO_OE       <= !CS_N && !cfg_ff.sync_mode && !CARD_IO_LINE_IN &&
                          !CARD_IO_LINE_OE;
      IO_PULLUP_EN     <= IO_PULLUP_SELECT;
    end
  end

  // Readback byte and interrupt pin; top three bits carry no data
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      READBACK  <= 8'h00;
      INT_N_OUT <= 1'b0;
      INT_N_OE  <= 1'b0;
    end else begin
      READBACK  <= 8'h00;
      READBACK[`SCS_RB_DET]  <= cfg_ff.special_mode ? CARD_PRESENCE_IN : present;
      READBACK[`SCS_RB_IO]   <= CARD_IO_LINE_IN;
      READBACK[`SCS_RB_AUXA] <= CARD_AUX_A_IN;
      READBACK[`SCS_RB_AUXB] <= CARD_AUX_B_IN;
      READBACK[`SCS_RB_PWR]  <= SUPPLY_OK;
      INT_N_OUT <= 1'b0;
      INT_N_OE  <= int_ins_ff || int_ovl_ff;
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  prog_fields_a: assert property (is_prog |=> card_ff.rst == $past(COMMAND_BYTE[4]) &&
    card_ff.div == $past(COMMAND_BYTE[3:2])) else $error("program byte fields lost");
  sync_data_a: assert property (is_sync && !pd_done |=> sdat_ff == $past(COMMAND_BYTE[3:0])
    && cfg_ff.sync_mode) else $error("sync byte not applied");
  reset_dflt_a: assert property (disable iff (1'b0) !RESET_N |=> !INT_N_OE && CARD_SUPPLY == 2'h0
    && CARD_CLOCK_DIV == 2'h0 && cfg_ff.special_mode && !cfg_ff.nc_switch && !cfg_ff.fast_slope)
    else $error("reset defaults wrong");
  rb_detect_a: assert property (##1 READBACK[4] == $past(cfg_ff.special_mode ?
    CARD_PRESENCE_IN : present)) else $error("readback bit 4 wrong");
  ramp_mask_a: assert property (supply_on && !ramped_ff |=> !CARD_RESET_OUT &&
    CARD_CLOCK_DIV == 2'h0 && !CARD_CLOCK_OUT) else $error("contacts live during ramp");
  pd_gap_a: assert property ($changed(pd_stage) && pd_stage > scs_pkg::PD_RST |->
    $past(pd_stage, GAP_CYC) == pd_stage - 3'h1) else $error("power-down step gap wrong");
  pd_clock_a: assert property (pd_stage >= scs_pkg::PD_CLK |=> CARD_CLOCK_DIV == 2'h0 &&
    !CARD_RESET_OUT) else $error("clock not low in power-down");
  fault_off_a: assert property (fault_det |-> ##1 pd_stage == scs_pkg::PD_RST ##0 !CONVERTER_EN
    ##1 INT_N_OE) else $error("fault reaction missing");
  int_set_a: assert property (filt_chg |=> ##1 INT_N_OE) else $error("event lost");
  int_clr_a: assert property (sel_clear && !filt_chg && !fault_det && !int_ovl_ff |=> ##1
    !INT_N_OE) else $error("interrupt not cleared");
  pullup_a: assert property (##1 IO_PULLUP_EN == $past(IO_PULLUP_SELECT))
    else $error("pullup select not followed");

  pd_run_c: cover property (pd_start ##[1:40] pd_done);
  insert_c: cover property (filt_chg ##[1:20] sel_clear);
  sync_c:   cover property (is_sync ##1 is_prog);
endmodule : scs_supervisor

// file: testbench/scs_card_model.sv
// Far-side model: card supply monitor and the open-drain card io wire.
// Assumes the supervisor drives the converter enable and the io pull-down.
`timescale 1ns/1ps
module scs_card_model #(
  parameter int RAMP = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic conv_en,
  input  wire logic fault,
  input  wire logic io_oe,
  input  wire logic card_low,
  output logic      supply_ok,
  output logic      above_min,
  output logic      io_level
);
  int ramp_ff;
  // Supply climbs only while the converter runs, and collapses at once when off
  always_ff @(posedge clk) begin
    if (!rst_n || !conv_en) begin
      ramp_ff <= 0;
    end else if (ramp_ff < RAMP) begin
      ramp_ff <= ramp_ff + 1;
    end
  end
  // Monitor view of the ramp; fault pulls the window flag low
  assign above_min = (ramp_ff == RAMP);
  assign supply_ok = above_min && !fault;
  // Pulled-up wire: any low driver wins, so released means high
  assign io_level = !(io_oe || card_low);
endmodule : scs_card_model

// file: testbench/scs_supervisor_bench.sv
// Self-checking bench for the supervisor with a card/supply model beside it.
// Assumes short filter and gap counts; expectations follow from them.
`timescale 1ns/1ps
module scs_supervisor_bench;
  localparam int FILT = 8;
  localparam int GAP  = 2;
  logic CLOCK = 1'b0;
  logic RESET_N, CS_N, CMD_VALID, CARD_PRESENCE_IN, SUPPLY_OK, SUPPLY_ABOVE_MIN;
  logic HOST_IO_IN, CARD_IO_LINE_IN, CARD_AUX_A_IN, CARD_AUX_B_IN, IO_PULLUP_SELECT;
  logic [7:0] COMMAND_BYTE, READBACK, b;
  logic [1:0] CARD_CLOCK_DIV, CARD_SUPPLY, addr;
  logic CARD_RESET_OUT, CARD_CLOCK_OUT, CLOCK_FAST_SLOPE, CONVERTER_EN;
  logic CARD_IO_LINE_OUT, CARD_IO_LINE_OE, HOST_IO_OUT, HOST_IO_OE;
  logic CARD_AUX_A_OUT, CARD_AUX_B_OUT, CARD_AUX_OE, IO_PULLUP_EN, INT_N_OUT, INT_N_OE;
  logic fault, card_low, host_low;
  int n_fail = 0;
  int cmp_count = 0;
  int tr, tc, ti, ts;
  logic [31:0] r;

  always #50 CLOCK = ~CLOCK;
  // Wire levels: aux pins show the driven value in sync mode, else the strap
  assign CARD_AUX_A_IN = CARD_AUX_OE ? CARD_AUX_A_OUT : addr[1];
  assign CARD_AUX_B_IN = CARD_AUX_OE ? CARD_AUX_B_OUT : addr[0];
  assign HOST_IO_IN = !(HOST_IO_OE || host_low); // Host line is pulled up

  scs_supervisor #(.FILT_CYC(FILT), .GAP_CYC(GAP)) dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CS_N(CS_N), .CMD_VALID(CMD_VALID),
    .COMMAND_BYTE(COMMAND_BYTE), .CARD_PRESENCE_IN(CARD_PRESENCE_IN),
    .SUPPLY_OK(SUPPLY_OK), .SUPPLY_ABOVE_MIN(SUPPLY_ABOVE_MIN), .HOST_IO_IN(HOST_IO_IN),
    .CARD_IO_LINE_IN(CARD_IO_LINE_IN), .CARD_AUX_A_IN(CARD_AUX_A_IN),
    .CARD_AUX_B_IN(CARD_AUX_B_IN), .IO_PULLUP_SELECT(IO_PULLUP_SELECT),
    .READBACK(READBACK), .CARD_RESET_OUT(CARD_RESET_OUT), .CARD_CLOCK_DIV(CARD_CLOCK_DIV),
    .CARD_CLOCK_OUT(CARD_CLOCK_OUT), .CLOCK_FAST_SLOPE(CLOCK_FAST_SLOPE),
    .CARD_SUPPLY(CARD_SUPPLY), .CONVERTER_EN(CONVERTER_EN),
    .CARD_IO_LINE_OUT(CARD_IO_LINE_OUT), .CARD_IO_LINE_OE(CARD_IO_LINE_OE),
    .HOST_IO_OUT(HOST_IO_OUT), .HOST_IO_OE(HOST_IO_OE), .CARD_AUX_A_OUT(CARD_AUX_A_OUT),
    .CARD_AUX_B_OUT(CARD_AUX_B_OUT), .CARD_AUX_OE(CARD_AUX_OE),
    .IO_PULLUP_EN(IO_PULLUP_EN), .INT_N_OUT(INT_N_OUT), .INT_N_OE(INT_N_OE));

  scs_card_model #(.RAMP(4)) card (
    .clk(CLOCK), .rst_n(RESET_N), .conv_en(CONVERTER_EN), .fault(fault),
    .io_oe(CARD_IO_LINE_OE), .card_low(card_low), .supply_ok(SUPPLY_OK),
    .above_min(SUPPLY_ABOVE_MIN), .io_level(CARD_IO_LINE_IN));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Inputs move a fixed 1 ns after the rising edge
  task automatic step(input int n = 1);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step

  // One byte with chip select low; an idle edge follows so valid never re-toggles
  task automatic send(input logic [7:0] v);
    CS_N = 1'b0;
    COMMAND_BYTE = v;
    CMD_VALID = 1'b1;
    step();
    CMD_VALID = 1'b0;
    step();
  endtask : send

  // First cycle of the reset, clock, io and supply power-down steps as seen at the pins
  task automatic pd_times();
    tr = -1; tc = -1; ti = -1; ts = -1;
    for (int k = 0; k < 60; k++) begin
      if (tr < 0 && CARD_RESET_OUT === 1'b0) tr = k;
      if (tc < 0 && CARD_CLOCK_DIV === 2'h0) tc = k;
      if (ti < 0 && CARD_IO_LINE_OE === 1'b1) ti = k;
      if (ts < 0 && CARD_SUPPLY === 2'h0) ts = k;
      step();
    end
  endtask : pd_times

  // Watchdog sized well past the few hundred cycles of the sequence
  initial begin
    #(100 * 3000);
    n_fail++;
    end_of_test();
  end

  initial begin
    RESET_N = 1'b0; CS_N = 1'b1; CMD_VALID = 1'b0; COMMAND_BYTE = 8'h00;
    CARD_PRESENCE_IN = 1'b0; IO_PULLUP_SELECT = 1'b0; addr = 2'h1;
    fault = 1'b0; card_low = 1'b0; host_low = 1'b0;
    r = $urandom(42);
    repeat (12) @(posedge CLOCK);
    #1;
    RESET_N = 1'b1;
    step();
    chk("supply", 8'h00, 8'(CARD_SUPPLY));
    chk("div", 8'h00, 8'(CARD_CLOCK_DIV));
    chk("slope", 8'h00, 8'(CLOCK_FAST_SLOPE));
    chk("int", 8'h00, 8'(INT_N_OE));
    // Insertion with chip select high; before the filter settles bit 4 is the raw pin
    CARD_PRESENCE_IN = 1'b1;
    step(3);
    chk("rb_raw", 8'h01, 8'(READBACK[4]));
    step(FILT + 4);
    chk("int_ins", 8'h01, 8'(INT_N_OE));
    chk("rb_poll", 8'h01, 8'(READBACK[4]));
    send(8'ha3);
    step(2);
    chk("int_clr", 8'h00, 8'(INT_N_OE));
    // Polarity in normal mode: a closed-switch setting reads a high pin as absent
    send(8'ha1);
    step(3);
    chk("det_nc", 8'h00, 8'(READBACK[4]));
    send(8'ha0);
    step(3);
    chk("det_no", 8'h01, 8'(READBACK[4]));
    send(8'ha5);
    chk("fast", 8'h01, 8'(CLOCK_FAST_SLOPE));
    send(8'ha4);
    chk("slow", 8'h00, 8'(CLOCK_FAST_SLOPE));
    // Contacts stay low during the ramp, then follow the programming byte
    send(8'h97);
    step(2);
    chk("rst_ramp", 8'h00, 8'(CARD_RESET_OUT));
    step(8);
    chk("prog97", 8'h17, {3'h0, CARD_RESET_OUT, CARD_CLOCK_DIV, CARD_SUPPLY});
    chk("rb_pwr", 8'h01, 8'(READBACK[0]));
    chk("od_low", 8'h00, {2'h0, READBACK[7:5], CARD_IO_LINE_OUT, HOST_IO_OUT, INT_N_OUT});
    for (int i = 1; i < 4; i++) begin
      r = $urandom;
      b = {3'h4, r[0], r[2:1], 2'(i)};
      send(b);
      step(2);
      chk("prog", b & 8'h1f, {3'h0, CARD_RESET_OUT, CARD_CLOCK_DIV, CARD_SUPPLY});
    end
    // Sync contacts, fixed example then random bytes; aux and io read back
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      b = (k == 0) ? 8'hd3 : {3'h6, r[4:0]};
      send(b);
      step(2);
      chk("aux_oe", 8'h01, 8'(CARD_AUX_OE));
      chk("sync", b & 8'h1f, {3'h0, CARD_RESET_OUT, CARD_CLOCK_OUT, CARD_IO_LINE_IN,
          CARD_AUX_A_OUT, CARD_AUX_B_OUT});
      chk("rb_sync", {5'h00, b[2:0]}, {5'h00, READBACK[3:1]});
    end
    send(8'h82);
    chk("sync_sup", 8'h02, 8'(CARD_SUPPLY));
    // Leave sync: a foreign address is ignored, own address programs
    send(8'hd1);
    send(8'h5f);
    step();
    chk("wrong_adr", 8'h02, 8'(CARD_SUPPLY));
    send(8'h3e);
    step();
    chk("async", 8'h1e, {2'h0, CARD_AUX_OE, CARD_RESET_OUT, CARD_CLOCK_DIV, CARD_SUPPLY});
    // Async io: host pin reaches the card only while selected, and back
    host_low = 1'b1;
    step(3);
    chk("io_async", 8'h01, 8'(CARD_IO_LINE_OE));
    chk("rb_io", 8'h00, 8'(READBACK[3]));
    CS_N = 1'b1;
    step(3);
    chk("io_cs_hi", 8'h00, 8'(CARD_IO_LINE_OE));
    host_low = 1'b0;
    card_low = 1'b1;
    CS_N = 1'b0;
    step(3);
    chk("io_to_host", 8'h01, 8'(HOST_IO_OE));
    card_low = 1'b0;
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      IO_PULLUP_SELECT = r[0];
      step(2);
      chk("pullup", 8'(r[0]), 8'(IO_PULLUP_EN));
    end
    // Extraction: filtered start, then the ordered steps a fixed gap apart
    CS_N = 1'b1;
    CARD_PRESENCE_IN = 1'b0;
    pd_times();
    chk("pd_filt", 8'h01, 8'(tr >= FILT && tr <= FILT + 5));
    chk("pd_gap", 8'(GAP), 8'(tc - tr));
    chk("pd_order", 8'h01, 8'(ti > tc && ts > ti));
    chk("pd_sup", 8'(4 * GAP), 8'(ts - tr));
    chk("int_ext", 8'h01, 8'(INT_N_OE));
    send(8'h20);
    step();
    chk("int_clr0", 8'h00, 8'(INT_N_OE));
    // Host power-down starts at once
    send(8'h9b);
    step(10);
    send(8'h98);
    pd_times();
    chk("pd_host", 8'h01, 8'(tr <= 3));
    chk("pd_hsup", 8'(4 * GAP), 8'(ts - tr));
    chk("int_hpd", 8'h00, 8'(INT_N_OE));
    // Supply fault: converter off, power-down, interrupt; cleared by a config byte
    send(8'h9b);
    step(10);
    fault = 1'b1;
    step(3);
    chk("conv_off", 8'h00, 8'(CONVERTER_EN));
    chk("rb_flt", 8'h00, 8'(READBACK[0]));
    chk("int_flt", 8'h01, 8'(INT_N_OE));
    step(20);
    chk("flt_sup", 8'h00, 8'(CARD_SUPPLY));
    fault = 1'b0;
    send(8'ha3);
    step();
    chk("int_clr1", 8'h00, 8'(INT_N_OE));
    end_of_test();
  end
endmodule : scs_supervisor_bench
